// file: rtl/cfm_cfg.svh
// Register map and field positions for the fault flag and mask block
`ifndef CFM_CFG_SVH
`define CFM_CFG_SVH
`define CFM_ADDR_FAULT_FLAGS_1 8'h27
`define CFM_ADDR_EVENT_IRQ_MASK_0 8'h28
`define CFM_RESET_VALUE 8'h00
`define CFM_BIT_SYSTEM_SHORT 7
`define CFM_BIT_SYSTEM_OVERVOLTAGE 6
`define CFM_BIT_REVERSE_OVERVOLTAGE 5
`define CFM_BIT_REVERSE_UNDERVOLTAGE 4
`define CFM_BIT_THERMAL_SHUTDOWN 2
`define CFM_FAULT_USED_MASK 8'hf4
`define CFM_BIT_INPUT_CURRENT_REG 7
`define CFM_BIT_INPUT_VOLTAGE_REG 6
`define CFM_BIT_WATCHDOG_EXPIRY 5
`define CFM_BIT_WEAK_SOURCE 4
`define CFM_BIT_POWER_GOOD 3
`define CFM_BIT_INPUT2_PRESENCE 2
`define CFM_BIT_INPUT1_PRESENCE 1
`define CFM_BIT_BUS_PRESENCE 0
`endif

// file: rtl/cfm_fault_mask.sv
// Fault flag register, event mask register and masked interrupt pulse
//
// Overview of operation
// - Fault flags at 27h, eight bits, read-only, zero
// - Bit 7 latches system short switching halt
// - Bit 6 latches system overvoltage switching halt
// - Bit 5 latches reverse output overvoltage stop
// - Bit 4 latches reverse output undervoltage stop
// - Bit 2 latches thermal shutdown rising edge
// - Mask at 28h, eight bits, read-write, zero
// - Register-reset command clears every mask bit
// - Mask bit 7 blocks current regulation pulse
// - Mask bit 6 blocks voltage regulation pulse
// - Mask bit 5 blocks watchdog expiry pulse
// - Mask bit 4 blocks weak source pulse
// - Mask bit 3 blocks power good toggle pulse
// - Mask bit 2 blocks second input presence pulse
// - Mask bit 1 blocks first input presence pulse
// - Mask bit 0 blocks bus presence pulse
// - Zero mask bit enables its event
`timescale 1ns/1ps
`include "cfm_cfg.svh"

module cfm_fault_mask (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_reset_cmd_in,
  input wire logic system_short_in,
  input wire logic system_overvoltage_in,
  input wire logic reverse_overvoltage_in,
  input wire logic reverse_undervoltage_in,
  input wire logic thermal_shutdown_in,
  input wire logic input_current_regulation_in,
  input wire logic reverse_current_regulation_in,
  input wire logic input_voltage_regulation_in,
  input wire logic reverse_voltage_regulation_in,
  input wire logic watchdog_expiry_in,
  input wire logic weak_source_in,
  input wire logic power_good_in,
  input wire logic second_input_present_in,
  input wire logic first_input_present_in,
  input wire logic bus_present_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_pulse_out
);

  // ==========================================================
  // Event detection
  cfm_pkg::cfm_byte_t fault_flags_1;
  cfm_pkg::cfm_byte_t event_irq_mask_0;
  cfm_pkg::cfm_byte_t fault_event;
  cfm_pkg::cfm_byte_t chg_event;
  logic thermal_prev;
  logic cur_reg_prev;
  logic volt_reg_prev;
  logic pg_prev;
  logic in2_prev;
  logic in1_prev;
  logic bus_prev;
  logic cur_reg_now;
  logic volt_reg_now;
  logic fault_read;
  logic mask_write;
  cfm_pkg::cfm_byte_t irq_hit;

  // ==========================================================
  // Helpers
  // Address match shared by the mask write and fault read-clear paths; the read data mux uses a case
  function automatic logic addr_hit(input cfm_pkg::cfm_byte_t addr,
                                    input cfm_pkg::cfm_byte_t target);
    return addr == target;
  endfunction : addr_hit

  // An event counts only while its mask bit is clear
  function automatic logic cfm_gate(input logic ev, input logic mask);
    return ev & ~mask;
  endfunction : cfm_gate

  assign cur_reg_now = input_current_regulation_in |
                       reverse_current_regulation_in;
  assign volt_reg_now = input_voltage_regulation_in |
                        reverse_voltage_regulation_in;
  assign fault_read = reg_rd_in &&
                      addr_hit(reg_addr_in, `CFM_ADDR_FAULT_FLAGS_1);
  assign mask_write = reg_wr_in &&
                      addr_hit(reg_addr_in, `CFM_ADDR_EVENT_IRQ_MASK_0);

  // Sources are on-chip on the same clock, so no synchroniser
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      thermal_prev <= 1'b0;
      cur_reg_prev <= 1'b0;
      volt_reg_prev <= 1'b0;
      pg_prev <= 1'b0;
      in2_prev <= 1'b0;
      in1_prev <= 1'b0;
      bus_prev <= 1'b0;
    end else begin
      thermal_prev <= thermal_shutdown_in;
      cur_reg_prev <= cur_reg_now;
      volt_reg_prev <= volt_reg_now;
      pg_prev <= power_good_in;
      in2_prev <= second_input_present_in;
      in1_prev <= first_input_present_in;
      bus_prev <= bus_present_in;
    end
  end

  always_comb begin
    fault_event = `CFM_RESET_VALUE;
    fault_event[`CFM_BIT_SYSTEM_SHORT] = system_short_in;
    fault_event[`CFM_BIT_SYSTEM_OVERVOLTAGE] = system_overvoltage_in;
    fault_event[`CFM_BIT_REVERSE_OVERVOLTAGE] = reverse_overvoltage_in;
    fault_event[`CFM_BIT_REVERSE_UNDERVOLTAGE] =
      reverse_undervoltage_in;
    fault_event[`CFM_BIT_THERMAL_SHUTDOWN] =
      thermal_shutdown_in & ~thermal_prev;
  end

  always_comb begin
    chg_event = `CFM_RESET_VALUE;
    // Regulation events count on entry only
    chg_event[`CFM_BIT_INPUT_CURRENT_REG] = cur_reg_now & ~cur_reg_prev;
    chg_event[`CFM_BIT_INPUT_VOLTAGE_REG] = volt_reg_now & ~volt_reg_prev;
    chg_event[`CFM_BIT_WATCHDOG_EXPIRY] = watchdog_expiry_in;
    chg_event[`CFM_BIT_WEAK_SOURCE] = weak_source_in;
    chg_event[`CFM_BIT_POWER_GOOD] = power_good_in ^ pg_prev;
    chg_event[`CFM_BIT_INPUT2_PRESENCE] = second_input_present_in ^ in2_prev;
    chg_event[`CFM_BIT_INPUT1_PRESENCE] = first_input_present_in ^ in1_prev;
    chg_event[`CFM_BIT_BUS_PRESENCE] = bus_present_in ^ bus_prev;
  end

  // ==========================================================
  // Fault flag register
  // Set wins over the read clear so no event is lost
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_flags_1 <= `CFM_RESET_VALUE;
    end else if (fault_read) begin
      fault_flags_1 <= fault_event & `CFM_FAULT_USED_MASK;
    end else begin
      fault_flags_1 <= (fault_flags_1 | fault_event) &
                       `CFM_FAULT_USED_MASK;
    end
  end

  // ==========================================================
  // Mask register
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      event_irq_mask_0 <= `CFM_RESET_VALUE;
    end else if (reg_reset_cmd_in) begin
      event_irq_mask_0 <= `CFM_RESET_VALUE;
    end else if (mask_write) begin
      event_irq_mask_0 <= reg_wdata_in;
    end
  end

  // ==========================================================
  // Read data and interrupt pulse
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= `CFM_RESET_VALUE;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `CFM_ADDR_FAULT_FLAGS_1: reg_rdata_out <= fault_flags_1;
        `CFM_ADDR_EVENT_IRQ_MASK_0: reg_rdata_out <= event_irq_mask_0;
        default: reg_rdata_out <= `CFM_RESET_VALUE;
      endcase
    end
  end

  // Per-event gating, kept bit by bit so each mask stays traceable
  always_comb begin
    irq_hit = `CFM_RESET_VALUE;
    irq_hit[`CFM_BIT_INPUT_CURRENT_REG] =
      cfm_gate(chg_event[`CFM_BIT_INPUT_CURRENT_REG],
               event_irq_mask_0[`CFM_BIT_INPUT_CURRENT_REG]);
    irq_hit[`CFM_BIT_INPUT_VOLTAGE_REG] =
      cfm_gate(chg_event[`CFM_BIT_INPUT_VOLTAGE_REG],
               event_irq_mask_0[`CFM_BIT_INPUT_VOLTAGE_REG]);
    irq_hit[`CFM_BIT_WATCHDOG_EXPIRY] =
      cfm_gate(chg_event[`CFM_BIT_WATCHDOG_EXPIRY],
               event_irq_mask_0[`CFM_BIT_WATCHDOG_EXPIRY]);
    irq_hit[`CFM_BIT_WEAK_SOURCE] =
      cfm_gate(chg_event[`CFM_BIT_WEAK_SOURCE],
               event_irq_mask_0[`CFM_BIT_WEAK_SOURCE]);
    irq_hit[`CFM_BIT_POWER_GOOD] =
      cfm_gate(chg_event[`CFM_BIT_POWER_GOOD],
               event_irq_mask_0[`CFM_BIT_POWER_GOOD]);
    irq_hit[`CFM_BIT_INPUT2_PRESENCE] =
      cfm_gate(chg_event[`CFM_BIT_INPUT2_PRESENCE],
               event_irq_mask_0[`CFM_BIT_INPUT2_PRESENCE]);
    irq_hit[`CFM_BIT_INPUT1_PRESENCE] =
      cfm_gate(chg_event[`CFM_BIT_INPUT1_PRESENCE],
               event_irq_mask_0[`CFM_BIT_INPUT1_PRESENCE]);
    irq_hit[`CFM_BIT_BUS_PRESENCE] =
      cfm_gate(chg_event[`CFM_BIT_BUS_PRESENCE],
               event_irq_mask_0[`CFM_BIT_BUS_PRESENCE]);
  end

  // One-cycle pulse per cycle with any unmasked event
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_pulse_out <= 1'b0;
    end else begin
      irq_pulse_out <= |irq_hit;
    end
  end

  // ==========================================================
  // Assertions
  a_short_latch: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    system_short_in |=> fault_flags_1[`CFM_BIT_SYSTEM_SHORT])
    else $error("short event not latched");
  a_ovp_latch: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    system_overvoltage_in |=> fault_flags_1[`CFM_BIT_SYSTEM_OVERVOLTAGE])
    else $error("overvoltage event not latched");
  a_otg_ovp_latch: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    reverse_overvoltage_in |=> fault_flags_1[`CFM_BIT_REVERSE_OVERVOLTAGE])
    else $error("reverse overvoltage not latched");
  a_otg_uvp_latch: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    reverse_undervoltage_in |=>
      fault_flags_1[`CFM_BIT_REVERSE_UNDERVOLTAGE])
    else $error("reverse undervoltage not latched");
  a_tshut_edge: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    $rose(thermal_shutdown_in) |=> fault_flags_1[`CFM_BIT_THERMAL_SHUTDOWN])
    else $error("thermal edge not latched");
  a_flag_sticky: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (fault_flags_1[`CFM_BIT_SYSTEM_SHORT] && !fault_read) |=>
      fault_flags_1[`CFM_BIT_SYSTEM_SHORT])
    else $error("flag lost before read");
  a_flags_keep: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    !fault_read |=>
      (fault_flags_1 & $past(fault_flags_1)) == $past(fault_flags_1))
    else $error("fault flag dropped without read");
  a_read_clear: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (fault_read && fault_event == `CFM_RESET_VALUE) |=>
      fault_flags_1 == `CFM_RESET_VALUE)
    else $error("fault flags not cleared by read");
  a_reserved_zero: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (fault_flags_1 & ~`CFM_FAULT_USED_MASK) == `CFM_RESET_VALUE)
    else $error("reserved fault bit set");
  a_regrst_mask: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    reg_reset_cmd_in |=> event_irq_mask_0 == `CFM_RESET_VALUE)
    else $error("mask not cleared by command");
  a_mask_write: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (mask_write && !reg_reset_cmd_in) |=>
      event_irq_mask_0 == $past(reg_wdata_in))
    else $error("mask write lost");
  a_mask_hold: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (!mask_write && !reg_reset_cmd_in) |=> $stable(event_irq_mask_0))
    else $error("mask changed without write");
  a_mask_blocks: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    ((chg_event & ~event_irq_mask_0) == `CFM_RESET_VALUE) |=>
      !irq_pulse_out)
    else $error("masked event raised pulse");
  a_curr_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    ($rose(input_current_regulation_in | reverse_current_regulation_in) &&
     !event_irq_mask_0[`CFM_BIT_INPUT_CURRENT_REG]) |=> irq_pulse_out)
    else $error("unmasked current regulation gave no pulse");
  a_volt_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    ($rose(input_voltage_regulation_in | reverse_voltage_regulation_in) &&
     !event_irq_mask_0[`CFM_BIT_INPUT_VOLTAGE_REG]) |=> irq_pulse_out)
    else $error("unmasked voltage regulation gave no pulse");
  a_wd_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (watchdog_expiry_in &&
     !event_irq_mask_0[`CFM_BIT_WATCHDOG_EXPIRY]) |=> irq_pulse_out)
    else $error("unmasked watchdog expiry gave no pulse");
  a_weak_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (weak_source_in &&
     !event_irq_mask_0[`CFM_BIT_WEAK_SOURCE]) |=> irq_pulse_out)
    else $error("unmasked weak source gave no pulse");
  a_pg_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    ($changed(power_good_in) &&
     !event_irq_mask_0[`CFM_BIT_POWER_GOOD]) |=> irq_pulse_out)
    else $error("unmasked power good toggle gave no pulse");
  a_in2_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    ($changed(second_input_present_in) &&
     !event_irq_mask_0[`CFM_BIT_INPUT2_PRESENCE]) |=> irq_pulse_out)
    else $error("unmasked second input change gave no pulse");
  a_in1_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    ($changed(first_input_present_in) &&
     !event_irq_mask_0[`CFM_BIT_INPUT1_PRESENCE]) |=> irq_pulse_out)
    else $error("unmasked first input change gave no pulse");
  a_bus_unmasked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    ($changed(bus_present_in) &&
     !event_irq_mask_0[`CFM_BIT_BUS_PRESENCE]) |-> ##1 irq_pulse_out)
    else $error("unmasked bus change gave no pulse");
  a_read_flags: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    fault_read |=> reg_rdata_out == $past(fault_flags_1))
    else $error("fault read data wrong");
  a_rdata_hold: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without read");
  a_unmapped_rd: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (reg_rd_in && !addr_hit(reg_addr_in, `CFM_ADDR_FAULT_FLAGS_1) &&
     !addr_hit(reg_addr_in, `CFM_ADDR_EVENT_IRQ_MASK_0)) |=>
      reg_rdata_out == `CFM_RESET_VALUE)
    else $error("unmapped read not zero");

  c_irq_pulse: cover property (@(posedge ref_clk_in) irq_pulse_out);
  c_thermal_flag: cover property (@(posedge ref_clk_in)
    fault_flags_1[`CFM_BIT_THERMAL_SHUTDOWN]);
  c_flag_read: cover property (@(posedge ref_clk_in)
    fault_read && fault_flags_1 != 8'h00);
  c_masked_pg: cover property (@(posedge ref_clk_in)
    chg_event[`CFM_BIT_POWER_GOOD] &&
    event_irq_mask_0[`CFM_BIT_POWER_GOOD]);
  c_regrst: cover property (@(posedge ref_clk_in)
    reg_reset_cmd_in && event_irq_mask_0 != 8'h00);

endmodule : cfm_fault_mask

// file: rtl/cfm_pkg.sv
// Types shared by the fault flag and mask block
package cfm_pkg;
  typedef logic [7:0] cfm_byte_t;
endpackage : cfm_pkg

// file: test/cfm_host_model.sv
// Host model driving the register port of the fault flag and mask block
`timescale 1ns/1ps
module cfm_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  // ==========
  // Bus cycles
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    // Released lines carry junk so stale values never look valid
    addr_out = ~a;
    wdata_out = ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    // Read data holds until the next read, so one spare cycle is safe
    @(negedge clk_in);
    d = rdata_in;
  endtask : read_reg
endmodule : cfm_host_model

// file: test/charger_fault_flags_irq_masks_test.sv
// Self-checking bench for the fault flag and mask block
`timescale 1ns/1ps
module charger_fault_flags_irq_masks_test;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic reg_reset_cmd_in = 1'b0;
  logic [4:0] flt = 5'h00;
  logic [9:0] ev = 10'h000;
  logic [7:0] addr, wdata, rdata, rd_val;
  logic wr, rd, irq;
  int bad_count = 0;
  int checked = 0;
  int pulses = 0;
  cfm_pkg::cfm_byte_t fexp [5] = '{8'h04, 8'h10, 8'h20, 8'h40, 8'h80};
  always #4 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (irq === 1'b1) pulses++;
  cfm_host_model host (.clk_in(ref_clk_in), .rdata_in(rdata),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  cfm_fault_mask uut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_reset_cmd_in(reg_reset_cmd_in),
    .system_short_in(flt[4]), .system_overvoltage_in(flt[3]),
    .reverse_overvoltage_in(flt[2]), .reverse_undervoltage_in(flt[1]),
    .thermal_shutdown_in(flt[0]), .input_current_regulation_in(ev[7]),
    .reverse_current_regulation_in(ev[9]),
    .input_voltage_regulation_in(ev[6]),
    .reverse_voltage_regulation_in(ev[8]), .watchdog_expiry_in(ev[5]),
    .weak_source_in(ev[4]), .power_good_in(ev[3]),
    .second_input_present_in(ev[2]), .first_input_present_in(ev[1]),
    .bus_present_in(ev[0]), .reg_rdata_out(rdata), .irq_pulse_out(irq));
  // ==========
  // Checking helpers
  task automatic chk(input string what, input cfm_pkg::cfm_byte_t got,
                     input cfm_pkg::cfm_byte_t exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    host.read_reg(a, rd_val);
    chk(what, rd_val, exp);
  endtask : rd_chk
  // Presence and power good toggles count both edges of the pulse
  task automatic fire(input int j, input logic [7:0] m, input int n);
    host.write_reg(8'h28, m);
    @(negedge ref_clk_in);
    pulses = 0;
    ev[j] = 1'b1;
    @(negedge ref_clk_in);
    ev[j] = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    chk("irq pulses", 8'(pulses), 8'(n));
  endtask : fire
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // ==========
  // Tests
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    int mb;
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    nrst_in = 1'b1;
    rd_chk("flags reset", 8'h27, 8'h00);
    rd_chk("mask reset", 8'h28, 8'h00);
    host.write_reg(8'h27, 8'hff);
    rd_chk("flags read-only", 8'h27, 8'h00);
    host.write_reg(8'h28, 8'ha5);
    rd_chk("mask readback", 8'h28, 8'ha5);
    rd_chk("unmapped read", 8'h30, 8'h00);
    @(negedge ref_clk_in);
    reg_reset_cmd_in = 1'b1;
    @(negedge ref_clk_in);
    reg_reset_cmd_in = 1'b0;
    rd_chk("mask after reset cmd", 8'h28, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      @(negedge ref_clk_in);
      flt[k] = 1'b1;
      @(negedge ref_clk_in);
      flt[k] = 1'b0;
      rd_chk("fault flag set", 8'h27, fexp[k]);
      rd_chk("fault flag cleared", 8'h27, 8'h00);
    end
    $display("test fault flags done");
    for (int j = 0; j < 10; j++) begin
      mb = (j > 7) ? j - 2 : j;
      fire(j, ~(8'h01 << mb), (mb < 4) ? 2 : 1);
      fire(j, 8'h01 << mb, 0);
    end
    $display("test interrupt masks done");
    wrap_up();
  end
endmodule : charger_fault_flags_irq_masks_test
